// ===== hdl/ubdr_core.v
// baud divisor registers, speed select and oversampling receiver
`timescale 1ns/1ps
`default_nettype none
`include "ubdr_consts.vh"

module ubdr_core #(
	parameter DIV_W = `UBDR_DIV_W
) (
	input  wire                    sys_clk,
	input  wire                    resetn,
	input  wire                    clk_en,
	input  wire                    rx_line,
	input  wire [`UBDR_ADDR_W-1:0] addr,
	input  wire [7:0]              wr_data,
	input  wire                    wr_en,
	input  wire                    rd_en,
	output reg  [7:0]              rd_data_q,
	output reg                     sample_tick_q,
	output reg  [7:0]              rx_shift_q,
	output reg                     bit_done_q,
	output reg                     char_done_q
);

	// receiver states
	localparam [1:0] ST_IDLE  = 2'b00;
	localparam [1:0] ST_START = 2'b01;
	localparam [1:0] ST_DATA  = 2'b10;
	localparam [1:0] ST_STOP  = 2'b11;

	// two-of-three vote
	function maj3;
		input a;
		input b;
		input c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	// registers seen by software
	reg [7:0]                 baud_divisor_low_q;
	reg [`UBDR_DIV_HI_W-1:0]  baud_divisor_high_q;
	reg                       speed_double_select_q;
	reg                       rx_complete_q;
	reg                       stop_low_q;
	reg [7:0]                 rx_byte_q;

	// receiver state
	reg [1:0]                 state_q;
	reg [`UBDR_CNT_W-1:0]     samp_q;
	reg [`UBDR_CNT_W-1:0]     bits_q;
	reg                       vote_a_q;
	reg                       vote_b_q;

	wire                      tick;
	wire [DIV_W-1:0]          baud_divisor_value;
	wire [`UBDR_CNT_W-1:0]    spb_last;
	wire [`UBDR_CNT_W-1:0]    mid;
	wire [`UBDR_CNT_W-1:0]    mid_lo;
	wire [`UBDR_CNT_W-1:0]    mid_hi;
	wire                      vote;
	wire                      wr_ctrl;
	wire                      set_done;

	assign baud_divisor_value = {baud_divisor_high_q, baud_divisor_low_q};

	// samples per bit and voting window by mode
	assign spb_last = speed_double_select_q ? `UBDR_SPB_DOUBLE : `UBDR_SPB_NORMAL;
	assign mid      = speed_double_select_q ? `UBDR_MID_DOUBLE : `UBDR_MID_NORMAL;
	assign mid_lo   = mid - `UBDR_SAMPLE_FIRST;
	assign mid_hi   = mid + `UBDR_SAMPLE_FIRST;

	// majority of the three window samples
	assign vote     = maj3(vote_a_q, vote_b_q, rx_line);
	assign wr_ctrl  = wr_en && (addr == `UBDR_ADDR_CTRL);
	assign set_done = tick && (state_q == ST_STOP) && (samp_q == mid_hi);

	// one tick per divisor plus one clocks
	// eight ticks per bit in double mode give f/(8(div+1))
	// sixteen ticks per bit in normal mode give f/(16(div+1))
	ubdr_baud_gen #(
		.DIV_W (DIV_W)
	) u_baud_gen (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clk_en  (clk_en),
		.divisor (baud_divisor_value),
		.tick_q  (tick)
	);

	// register writes and completion flag
	always @(posedge sys_clk) begin
		if (!resetn) begin
			baud_divisor_low_q    <= `UBDR_RST_DIV_LO;
			baud_divisor_high_q   <= `UBDR_RST_DIV_HI;
			speed_double_select_q <= 1'b0;
			rx_complete_q         <= 1'b0;
		end else if (clk_en) begin
			if (wr_en && (addr == `UBDR_ADDR_DIV_LO)) begin
				baud_divisor_low_q <= wr_data;
			end
			if (wr_en && (addr == `UBDR_ADDR_DIV_HI)) begin
				baud_divisor_high_q <= wr_data[`UBDR_DIV_HI_W-1:0];
			end
			if (wr_ctrl) begin
				speed_double_select_q <= wr_data[`UBDR_CTRL_DBL_BIT];
			end
			// hardware set wins over write-one clear
			if (set_done) begin
				rx_complete_q <= 1'b1;
			end else if (wr_ctrl && wr_data[`UBDR_CTRL_DONE_BIT]) begin
				rx_complete_q <= 1'b0;
			end
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always @(posedge sys_clk) begin
		if (!resetn) begin
			rd_data_q <= `UBDR_RST_BYTE;
		end else if (clk_en) begin
			rd_data_q <= `UBDR_RST_BYTE;
			if (rd_en) begin
				case (addr)
				`UBDR_ADDR_DIV_LO: begin
					rd_data_q <= baud_divisor_low_q;
				end
				`UBDR_ADDR_DIV_HI: begin
					rd_data_q <= {4'h0, baud_divisor_high_q}; // top bits read zero
				end
				`UBDR_ADDR_CTRL: begin
					rd_data_q <= {rx_complete_q, 2'b00, stop_low_q, 2'b00,
						speed_double_select_q, 1'b0};
				end
				`UBDR_ADDR_RXDATA: begin
					rd_data_q <= rx_byte_q;
				end
				default: begin
					rd_data_q <= `UBDR_RST_BYTE;
				end
				endcase
			end
		end
	end

	// receiver state machine, advanced on sample ticks
	always @(posedge sys_clk) begin
		if (!resetn) begin
			state_q       <= ST_IDLE;
			samp_q        <= {`UBDR_CNT_W{1'b0}};
			bits_q        <= {`UBDR_CNT_W{1'b0}};
			vote_a_q      <= 1'b1;
			vote_b_q      <= 1'b1;
			rx_shift_q    <= `UBDR_RST_BYTE;
			rx_byte_q     <= `UBDR_RST_BYTE;
			stop_low_q    <= 1'b0;
			bit_done_q    <= 1'b0;
			char_done_q   <= 1'b0;
			sample_tick_q <= 1'b0;
		end else if (clk_en) begin
			bit_done_q    <= 1'b0;
			char_done_q   <= 1'b0;
			sample_tick_q <= tick;
			if (tick) begin
				// window samples
				if (samp_q == mid_lo) begin
					vote_a_q <= rx_line;
				end
				if (samp_q == mid) begin
					vote_b_q <= rx_line;
				end
				case (state_q)
				ST_IDLE: begin
					// one low sample marks the start edge
					if (!rx_line) begin
						samp_q  <= `UBDR_SAMPLE_FIRST;
						state_q <= ST_START;
					end
				end
				ST_START: begin
					// two or more high samples reject the start bit
					if ((samp_q == mid_hi) && vote) begin
						state_q <= ST_IDLE;
						samp_q  <= {`UBDR_CNT_W{1'b0}};
					end else if (samp_q == spb_last) begin
						samp_q  <= {`UBDR_CNT_W{1'b0}};
						bits_q  <= {`UBDR_CNT_W{1'b0}};
						state_q <= ST_DATA;
					end else begin
						samp_q <= samp_q + `UBDR_SAMPLE_FIRST;
					end
				end
				ST_DATA: begin
					// shift at the moment the vote is known
					if (samp_q == mid_hi) begin
						rx_shift_q <= {vote, rx_shift_q[7:1]};
						bits_q     <= bits_q + `UBDR_SAMPLE_FIRST;
						bit_done_q <= 1'b1;
					end
					if (samp_q == spb_last) begin
						samp_q <= {`UBDR_CNT_W{1'b0}};
						if (bits_q == `UBDR_DATA_BITS) begin
							state_q <= ST_STOP;
						end
					end else begin
						samp_q <= samp_q + `UBDR_SAMPLE_FIRST;
					end
				end
				ST_STOP: begin
					// stop bit voted the same way
					if (samp_q == mid_hi) begin
						rx_byte_q   <= rx_shift_q;
						stop_low_q  <= ~vote;
						char_done_q <= 1'b1;
						state_q     <= ST_IDLE;
						samp_q      <= {`UBDR_CNT_W{1'b0}};
					end else begin
						samp_q <= samp_q + `UBDR_SAMPLE_FIRST;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ===== hdl/ubdr_consts.vh
// constants for the baud generator and double-speed receiver
`ifndef UBDR_CONSTS_VH
`define UBDR_CONSTS_VH

// register offsets
`define UBDR_ADDR_W          6
`define UBDR_ADDR_DIV_LO     6'h09
`define UBDR_ADDR_DIV_HI     6'h20
`define UBDR_ADDR_CTRL       6'h0B
`define UBDR_ADDR_RXDATA     6'h0C

// reset values
`define UBDR_RST_DIV_LO      8'h00
`define UBDR_RST_DIV_HI      4'h0
`define UBDR_RST_BYTE        8'h00

// control and status field positions
`define UBDR_CTRL_DBL_BIT    1
`define UBDR_CTRL_STOP_BIT   4
`define UBDR_CTRL_DONE_BIT   7

// divisor width and field split
`define UBDR_DIV_W           12
`define UBDR_DIV_HI_W        4

// sampling: last sample index per bit and middle sample per mode
`define UBDR_SPB_NORMAL      4'hF
`define UBDR_SPB_DOUBLE      4'h7
`define UBDR_MID_NORMAL      4'h9
`define UBDR_MID_DOUBLE      4'h5
`define UBDR_SAMPLE_FIRST    4'h1
`define UBDR_CNT_W           4

// character layout
`define UBDR_DATA_BITS       4'h8

`endif

// ===== hdl/ubdr_baud_gen.v
// sample tick generator dividing the system clock by divisor plus one
`timescale 1ns/1ps
`default_nettype none
`include "ubdr_consts.vh"

module ubdr_baud_gen #(
	parameter DIV_W = `UBDR_DIV_W
) (
	input  wire             sys_clk,
	input  wire             resetn,
	input  wire             clk_en,
	input  wire [DIV_W-1:0] divisor,
	output reg              tick_q
);

	reg [DIV_W-1:0] cnt_q;

	// down counter, tick and reload at zero
	always @(posedge sys_clk) begin
		if (!resetn) begin
			cnt_q  <= {DIV_W{1'b0}};
			tick_q <= 1'b0;
		end else if (clk_en) begin
			if (cnt_q == {DIV_W{1'b0}}) begin
				cnt_q  <= divisor; // any value 0..4095 works
				tick_q <= 1'b1;
			end else begin
				cnt_q  <= cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
				tick_q <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// ===== sim/ubdr_monitor.sv
// checker for divisor registers, tick rate and receive votes
`timescale 1ns/1ps
`default_nettype none
`include "ubdr_consts.vh"
module ubdr_monitor #(
	parameter DIV_W = `UBDR_DIV_W
) (
	input wire logic                    sys_clk,
	input wire logic                    resetn,
	input wire logic                    clk_en,
	input wire logic                    rx_line,
	input wire logic [`UBDR_ADDR_W-1:0] addr,
	input wire logic [7:0]              wr_data,
	input wire logic                    wr_en,
	input wire logic                    rd_en,
	input wire logic [7:0]              rd_data_q,
	input wire logic                    sample_tick_q,
	input wire logic [7:0]              rx_shift_q,
	input wire logic                    bit_done_q,
	input wire logic                    char_done_q
);
	logic [7:0]  lo_q;
	logic [3:0]  hi_q;
	logic [11:0] gap_q;
	logic [2:0]  smp_q;
	logic [3:0]  nb_q;
	logic        rx_d_q, wp_q, wrote_q, armed_q;
	wire         dw = wr_en && (addr == `UBDR_ADDR_DIV_LO || addr == `UBDR_ADDR_DIV_HI);
	// vote sample is still in rx_d_q when bit done shows, the two earlier ones in smp_q
	wire         maj = (smp_q[0] & smp_q[1]) | (smp_q[1] & rx_d_q) | (smp_q[0] & rx_d_q);
	// shadow divisor, tick gap, vote samples and bit count
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			{lo_q, hi_q, gap_q, smp_q, nb_q} <= '0;
			{rx_d_q, wp_q, wrote_q, armed_q} <= '0;
		end else if (clk_en) begin
			rx_d_q <= rx_line;
			wp_q <= dw;
			if (wr_en && addr == `UBDR_ADDR_DIV_LO) lo_q <= wr_data;
			if (wr_en && addr == `UBDR_ADDR_DIV_HI) hi_q <= wr_data[3:0];
			gap_q <= sample_tick_q ? 12'h000 : gap_q + 12'h001;
			armed_q <= armed_q | sample_tick_q;
			wrote_q <= sample_tick_q ? (dw | wp_q) : (wrote_q | dw);
			if (sample_tick_q) smp_q <= {smp_q[1:0], rx_d_q};
			nb_q <= char_done_q ? 4'h0 : nb_q + {3'h0, bit_done_q};
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_low_next;
		##1 !char_done_q;
	endsequence
	a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data_q == 8'h00)
		else $error("read data not zero outside read");
	a_lo_read: assert property (rd_en && addr == `UBDR_ADDR_DIV_LO |=> rd_data_q == lo_q)
		else $error("low divisor readback wrong");
	a_hi_read: assert property (rd_en && addr == `UBDR_ADDR_DIV_HI |=> rd_data_q == {4'h0, hi_q})
		else $error("high divisor readback wrong");
	a_tick_period: assert property (sample_tick_q && armed_q && !wrote_q |-> gap_q == {hi_q, lo_q})
		else $error("tick spacing not divisor plus one");
	a_shift_done: assert property ($changed(rx_shift_q) |-> bit_done_q)
		else $error("shift without bit done");
	a_bit_vote: assert property (bit_done_q |-> rx_shift_q[7] == maj)
		else $error("bit value not majority");
	a_char_bits: assert property (char_done_q |-> nb_q == 4'h8)
		else $error("character without eight bits");
	a_char_pulse: assert property (char_done_q |-> s_low_next)
		else $error("character done too long");
endmodule
bind ubdr_core ubdr_monitor #(.DIV_W(DIV_W)) ubdr_monitor_i (.sys_clk(sys_clk), .resetn(resetn),
	.clk_en(clk_en), .rx_line(rx_line), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data_q(rd_data_q), .sample_tick_q(sample_tick_q), .rx_shift_q(rx_shift_q),
	.bit_done_q(bit_done_q), .char_done_q(char_done_q));
`default_nettype wire

// ===== sim/ubdr_tx_model.sv
// serial transmitter standing on the receive line
`timescale 1ns/1ps
`default_nettype none
module ubdr_tx_model (
	input  wire logic        sys_clk,
	input  wire logic        go,
	input  wire logic [7:0]  data,
	input  wire logic        stop_val,
	input  wire logic        glitch,
	input  wire logic [15:0] bit_clks,
	output var  logic        line,
	output var  logic        busy
);
	logic [9:0] frame;
	// frame sender, line idles high between frames
	initial begin
		line = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (go) begin
				busy <= 1'b1;
				frame = {stop_val, data, 1'b0};
				for (int i = 0; i < (glitch ? 1 : 10); i++) begin
					line <= frame[i];
					repeat (bit_clks) @(posedge sys_clk);
				end
				line <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// bench for the divisor registers and double-speed receiver
`timescale 1ns/1ps
`default_nettype none
`include "ubdr_consts.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
	logic                    sys_clk, resetn, wr_en, rd_en, rx_line, tick, bdone, cdone;
	logic                    clk_en = 1'b1;
	logic                    tx_go, tx_stop, tx_glitch, tx_busy;
	logic [`UBDR_ADDR_W-1:0] addr;
	logic [7:0]              wr_data, rd_data_q, rx_shift_q, tx_data;
	logic [15:0]             tx_len;
	int                      err_count = 0;
	int                      num_checks = 0;
	ubdr_core ubdr_core_i (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .rx_line(rx_line),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
		.sample_tick_q(tick), .rx_shift_q(rx_shift_q), .bit_done_q(bdone), .char_done_q(cdone));
	ubdr_tx_model ubdr_tx_model_i (.sys_clk(sys_clk), .go(tx_go), .data(tx_data), .stop_val(tx_stop),
		.glitch(tx_glitch), .bit_clks(tx_len), .line(rx_line), .busy(tx_busy));
	task automatic summarize;
		if (err_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [`UBDR_ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [`UBDR_ADDR_W-1:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		`CHK(rd_data_q, e)
	endtask
	task automatic send(input logic [7:0] d, input logic s, input logic g, input logic [15:0] n);
		@(posedge sys_clk);
		{tx_data, tx_stop, tx_glitch, tx_len} <= {d, s, g, n};
		tx_go <= 1'b1;
		@(posedge sys_clk);
		tx_go <= 1'b0;
		repeat (2) @(posedge sys_clk);
		while (tx_busy) @(posedge sys_clk);
		repeat (20) @(posedge sys_clk);
	endtask
	// free running system clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// hang guard
	initial begin
		#400000;
		err_count++;
		summarize;
	end
	// main sequence
	initial begin
		{resetn, wr_en, rd_en, tx_go, tx_stop, tx_glitch} = 6'h00;
		{addr, wr_data, tx_data, tx_len} = '0;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(`UBDR_ADDR_DIV_LO, 8'h00);
		rd(`UBDR_ADDR_DIV_HI, 8'h00);
		rd(`UBDR_ADDR_CTRL, 8'h00);
		rd(`UBDR_ADDR_RXDATA, 8'h00);
		rd(6'h3F, 8'h00);
		wr(`UBDR_ADDR_DIV_LO, 8'hFF);
		wr(`UBDR_ADDR_DIV_HI, 8'hFF);
		rd(`UBDR_ADDR_DIV_HI, 8'h0F);
		rd(`UBDR_ADDR_DIV_LO, 8'hFF);
		repeat (9000) @(posedge sys_clk);
		wr(`UBDR_ADDR_DIV_LO, 8'h01);
		wr(`UBDR_ADDR_DIV_HI, 8'h00);
		repeat (4200) @(posedge sys_clk);
		wr(`UBDR_ADDR_CTRL, 8'h02);
		send(8'h00, 1'b1, 1'b1, 16'd4);
		rd(`UBDR_ADDR_CTRL, 8'h02);
		send(8'h3C, 1'b1, 1'b0, 16'd16);
		`CHK(rx_shift_q, 8'h3C)
		rd(`UBDR_ADDR_RXDATA, 8'h3C);
		rd(`UBDR_ADDR_CTRL, 8'h82);
		wr(`UBDR_ADDR_CTRL, 8'h80);
		send(8'hA5, 1'b0, 1'b0, 16'd32);
		rd(`UBDR_ADDR_RXDATA, 8'hA5);
		rd(`UBDR_ADDR_CTRL, 8'h90);
		summarize;
	end
endmodule
`default_nettype wire
